// [sim/cpwm_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cpwm_defs.svh"
module cpwm_bench;
	logic        clock_in, reset_n_in, psel, penable, pwrite, pready, pslverr, ext_a, ext_b, tgl;
	logic        er, sd, su, lo2;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, x, c;
	logic [5:0]  pins;
	logic [15:0] dead_val;
	int          bad_count, check_count, seed, ovl, gapf, p, ovl0, gap0;

	cpwm_top #(.FIRST_PAIR(1), .W(16)) dut_u (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
		.prdata_out(prdata), .pslverr_out(pslverr), .ext_clock_pin_a_in(ext_a),
		.ext_clock_pin_b_in(ext_b), .carrier_toggle_pin_out(tgl),
		.phase1_normal_pin_out(pins[0]), .phase1_inverted_pin_out(pins[1]),
		.phase2_normal_pin_out(pins[2]), .phase2_inverted_pin_out(pins[3]),
		.phase3_normal_pin_out(pins[4]), .phase3_inverted_pin_out(pins[5]));
	cpwm_gate_model gate_u (.clock_in(clock_in), .reset_n_in(reset_n_in), .pins_in(pins),
		.dead_in(dead_val), .overlap_out(ovl), .gap_out(gapf));

	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// request held from setup until pready is seen high at a rising edge
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clock_in);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			finish_test();
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(nm, e, rd);
	endtask

	// spacing of toggle changes, one carrier period each
	task period(output int q);
		logic t0;
		int   n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			t0 = tgl;
			do begin
				@(negedge clock_in);
				n++;
			end while (tgl === t0 && n < 9000);
		end
		q = n;
	endtask

	function automatic int ratio(input int k);
		int r [9] = '{1, 2, 4, 8, 16, 32, 64, 256, 1024};
		return r[k];
	endfunction

	function automatic logic [31:0] exp_cfg(input logic [31:0] d);
		logic [31:0] v;
		v = {14'h0, d[17:0]};
		if (v[1:0] != `CPWM_MODE_BOTH) v[14] = 1'b0;
		return v;
	endfunction

	function automatic logic [5:0] idle_pins(input logic [5:0] o);
		return ~{o[5], o[2], o[4], o[1], o[3], o[0]};
	endfunction

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 64006;
		bad_count = 0; check_count = 0;
		psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		ext_a = 1'b0; ext_b = 1'b0; dead_val = 16'h0000; reset_n_in = 1'b0;
		repeat (16) @(posedge clock_in);
		reset_n_in <= 1'b1;
		@(negedge clock_in);
		chk("reset pins", 32'h3F, pins);
		rdchk("cfg reset", `CPWM_OFF_CFG, `CPWM_CFG_RST);
		rdchk("cycle reset", `CPWM_OFF_CYCLE, `CPWM_CYC_RST);
		rdchk("wprot reset", `CPWM_OFF_WPROT, `CPWM_WP_RST);
		rdchk("status reset", `CPWM_OFF_STATUS, 32'h0);
		xfer(8'h40, 1'b0, 32'h0);
		chk("unmapped err", 32'h1, er);
		chk("unmapped data", 32'h0, rd);
		for (int m = 0; m < 4; m++) begin
			wr(`CPWM_OFF_CFG, 32'h4000 | m);
			rdchk("cfg mode", `CPWM_OFF_CFG, exp_cfg(32'h4000 | m));
		end
		repeat (10) begin
			x = $random(seed);
			x[5:2] = 4'((x[31:16] & 16'h7FFF) % 9);
			if (x[9:8] == 2'h3) x[9:8] = 2'h0;
			wr(`CPWM_OFF_CFG, x);
			rdchk("cfg rand", `CPWM_OFF_CFG, exp_cfg(x));
		end
		wr(`CPWM_OFF_CFG, 32'h1);
		repeat (6) begin
			x = $random(seed);
			wr(`CPWM_OFF_OCR1, {26'h0, x[5:0]});
			repeat (3) @(posedge clock_in);
			@(negedge clock_in);
			chk("idle pins", idle_pins(x[5:0]), pins);
		end
		wr(`CPWM_OFF_OCR1, 32'h0);
		wr(`CPWM_OFF_CYCLE, 32'h20);
		wr(`CPWM_OFF_WPROT, 32'h0);
		wr(`CPWM_OFF_CYCLE, 32'h37);
		rdchk("protected cycle", `CPWM_OFF_CYCLE, 32'h20);
		wr(`CPWM_OFF_WPROT, 32'h1);
		wr(`CPWM_OFF_CYCLE, 32'h0);
		rdchk("cycle floor", `CPWM_OFF_CYCLE, 32'h1);
		wr(`CPWM_OFF_CYCLE, 32'h2);
		for (int k = 0; k < 9; k++) begin
			// divide-by-one also given both edges, which must be ignored
			wr(`CPWM_OFF_CFG, 32'h401 | (k << 2) | ((k == 0) ? 32'h80 : 32'h0));
			wr(`CPWM_OFF_RUN, 32'h1);
			period(p);
			chk("toggle period", 4 * ratio(k), p);
			wr(`CPWM_OFF_RUN, 32'h0);
		end
		wr(`CPWM_OFF_CYCLE, 32'd100);
		for (int s = 1; s < 3; s++) begin
			// pin b counts both edges
			wr(`CPWM_OFF_CFG, 32'h1 | (s << 8) | ((s == 2) ? 32'h80 : 32'h0));
			wr(`CPWM_OFF_RUN, 32'h1);
			// the counter starts one edge after run lands; an earlier edge is lost
			repeat (2) @(posedge clock_in);
			for (int k = 0; k < 6; k++) begin
				ext_a <= (k < 4);
				ext_b <= 1'b1;
				repeat (3) @(posedge clock_in);
				ext_a <= 1'b0;
				ext_b <= 1'b0;
				repeat (3) @(posedge clock_in);
			end
			repeat (4) @(posedge clock_in);
			rdchk("ext count", `CPWM_OFF_COUNT, (s == 1) ? 32'd4 : 32'd12);
			chk("toggle off", 32'h0, tgl);
			wr(`CPWM_OFF_RUN, 32'h0);
		end
		c = 32'd20 + ((($random(seed)) & 32'hFF) % 40);
		dead_val = 16'(1 + (($random(seed)) & 32'h3));
		wr(`CPWM_OFF_CYCLE, c);
		wr(`CPWM_OFF_DEAD, {16'h0, dead_val});
		for (int k = 0; k < 3; k++) begin
			// phase two held at half duty so its normal pin surely goes active
			x = (($random(seed)) & 32'h3FF) % 1001;
			if (k == 1) x = 32'd500;
			wr(`CPWM_OFF_CMP0 + 8'(4 * k), (((c * x) / 1000) << 1) | ($random(seed) & 32'h1));
		end
		// mode 3, double buffer, buffered level with crest and trough transfer
		wr(`CPWM_OFF_CFG, 32'h37C03);
		// idle patterns above may look like shoot-through to the gate model
		ovl0 = ovl;
		gap0 = gapf;
		wr(`CPWM_OFF_RUN, 32'h1);
		sd = 1'b0; su = 1'b0; lo2 = 1'b0;
		repeat (60) begin
			repeat (($random(seed)) & 32'h7) @(posedge clock_in);
			xfer(`CPWM_OFF_STATUS, 1'b0, 32'h0);
			chk("running", 32'h1, rd[0]);
			if (rd[1] === 1'b1) sd = 1'b1;
			if (rd[1] === 1'b0) su = 1'b1;
			xfer(`CPWM_OFF_COUNT, 1'b0, 32'h0);
			if (rd > c) chk("count range", c, rd);
			@(negedge clock_in);
			chk("pair one off", 32'h3, pins[1:0]);
			if (pins[2] === 1'b0) lo2 = 1'b1;
		end
		chk("both directions", 32'h1, sd & su);
		chk("pair two active", 32'h1, lo2);
		chk("overlaps", 32'h0, ovl - ovl0);
		chk("short dead gaps", 32'h0, gapf - gap0);
		wr(`CPWM_OFF_RUN, 32'h0);
		rdchk("stopped", `CPWM_OFF_STATUS, 32'h0);
		finish_test();
	end

	initial begin
		#10000000;
		bad_count++;
		finish_test();
	end
endmodule // cpwm_bench
`default_nettype wire

// [sim/cpwm_gate_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpwm_gate_model (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	// gate pins {p3i,p3n,p2i,p2n,p1i,p1n}, low turns a switch on
	input  wire logic [5:0]  pins_in,
	input  wire logic [15:0] dead_in,
	// fault tallies
	output var int           overlap_out,
	output var int           gap_out
);
	int         idle_q [3];
	logic [5:0] prev_q;

	// ----------------------------------------
	// shoot-through and dead-gap watch
	// ----------------------------------------
	always @(posedge clock_in) begin
		if (!reset_n_in) begin
			overlap_out = 0;
			gap_out = 0;
			prev_q = 6'h3F;
			for (int k = 0; k < 3; k++) idle_q[k] = 65536;
		end else begin
			for (int k = 0; k < 3; k++) begin
				// both switches of one leg on shorts the supply rail
				if (pins_in[2*k+:2] == 2'h0) overlap_out++;
				if (pins_in[2*k+:2] == 2'h3) begin
					if (idle_q[k] < 65536) idle_q[k]++;
				end else begin
					if (prev_q[2*k+:2] == 2'h3 && idle_q[k] < int'(dead_in)) gap_out++;
					idle_q[k] = 0;
				end
			end
			prev_q = pins_in;
		end
	end
endmodule // cpwm_gate_model
`default_nettype wire

// [src/cpwm_defs.svh]
`ifndef CPWM_DEFS_SVH
`define CPWM_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CPWM_OFF_RUN    8'h00
`define CPWM_OFF_CFG    8'h04
`define CPWM_OFF_CYCLE  8'h08
`define CPWM_OFF_DEAD   8'h0C
`define CPWM_OFF_OCR1   8'h10
`define CPWM_OFF_OCR2   8'h14
`define CPWM_OFF_LVLBUF 8'h18
`define CPWM_OFF_WPROT  8'h1C
`define CPWM_OFF_CMP0   8'h20
`define CPWM_OFF_CMP1   8'h24
`define CPWM_OFF_CMP2   8'h28
`define CPWM_OFF_STATUS 8'h2C
`define CPWM_OFF_COUNT  8'h30
// ----------------------------------------
// widths, fields and reset values
// ----------------------------------------
`define CPWM_CFG_W      18
`define CPWM_CMP_W      17
`define CPWM_OCR_W      6
`define CPWM_CFG_RST    18'h00001
`define CPWM_CYC_RST    16'h0001
`define CPWM_CYC_MIN    16'h0001
`define CPWM_WP_RST     1'h1
`define CPWM_CREST      0
`define CPWM_TROUGH     1
`define CPWM_MODE_BOTH  2'h3
`define CPWM_SRC_INT    2'h0
`define CPWM_SRC_PIN_A  2'h1
`define CPWM_SRC_PIN_B  2'h2
`define CPWM_EDGE_RISE  2'h0
`define CPWM_EDGE_FALL  2'h1
`define CPWM_EDGE_BOTH  1
`define CPWM_DIV_ONE    4'h0
`define CPWM_DIV_TWO    4'h1
// prescaler bit per ratio code 0..8 (1,2,4,8,16,32,64,256,1024)
`define CPWM_DIV_IDX    {4'h9, 4'h7, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0, 4'h0}
`define CPWM_PRESC_W    10
`define CPWM_ST_RUN     0
`define CPWM_ST_DOWN    1
`endif

// [src/cpwm_phase.sv]
`timescale 1ns/1ps
`default_nettype none
module cpwm_phase #(parameter int W = 16) (
	// clock and reset
	input  wire logic   clock_in,
	input  wire logic   reset_n_in,
	// carrier state
	cpwm_phase_if.phase ph,
	// pin pair
	output var logic    normal_out,
	output var logic    inverted_out
);
	logic         raw;
	logic         raw_q;
	logic [W-1:0] dt_q;
	logic         act_n;
	logic         act_i;

	// normal phase owns the region around the crest
	assign raw   = ph.down ? (ph.cnt >= ph.cmp_dn) : (ph.cnt >= ph.cmp_up);
	// both phases wait out the dead time after any edge of raw
	assign act_n = ph.running & ph.pair_en & raw_q & (dt_q == '0);
	assign act_i = ph.running & ph.pair_en & ~raw_q & (dt_q == '0);

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			raw_q <= 1'h0;
			dt_q  <= '0;
		end else if (!ph.running) begin
			raw_q <= 1'h0;
			dt_q  <= ph.dead;
		end else if (ph.tick) begin
			raw_q <= raw;
			if (raw != raw_q) begin
				dt_q <= ph.dead;
			end else if (dt_q != '0) begin
				dt_q <= dt_q - 1'h1;
			end
		end
	end

	// polarity 0: idle high, active low; polarity 1: the complement
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			normal_out   <= 1'h1;
			inverted_out <= 1'h1;
		end else begin
			normal_out   <= ph.pol_n ? act_n : ~act_n;
			inverted_out <= ph.pol_i ? act_i : ~act_i;
		end
	end

	property p_no_overlap;
		@(posedge clock_in) disable iff (!reset_n_in)
		(normal_out == $past(ph.pol_n)) |-> (inverted_out != $past(ph.pol_i));
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both phases active");

	property p_dead_gap;
		@(posedge clock_in) disable iff (!reset_n_in)
		ph.running && ph.tick && (raw != raw_q) && (ph.dead != '0)
			|=> (dt_q == $past(ph.dead)) && !act_n && !act_i;
	endproperty
	a_dead_gap: assert property (p_dead_gap) else $error("dead time not inserted");

	property p_idle_level;
		@(posedge clock_in) disable iff (!reset_n_in)
		!ph.pair_en |=> (normal_out == !$past(ph.pol_n)) && (inverted_out == !$past(ph.pol_i));
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("disabled pair not idle");
endmodule // cpwm_phase
`default_nettype wire

// [src/cpwm_phase_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cpwm_phase_if #(parameter int W = 16);
	logic         tick;
	logic         running;
	logic         down;
	logic [W-1:0] cnt;
	logic [W-1:0] cmp_up;
	logic [W-1:0] cmp_dn;
	logic [W-1:0] dead;
	logic         pol_n;
	logic         pol_i;
	logic         pair_en;
	modport timer (output tick, running, down, cnt, cmp_up, cmp_dn, dead, pol_n, pol_i, pair_en);
	modport phase (input tick, running, down, cnt, cmp_up, cmp_dn, dead, pol_n, pol_i, pair_en);
endinterface
`default_nettype wire

// [src/cpwm_pkg.sv]
package cpwm_pkg;
	typedef struct packed {
		logic [2:0] pair_en;
		logic       dbuf;
		logic [1:0] lvl_trig;
		logic       lvl_buffered;
		logic       toggle_en;
		logic [1:0] clk_src;
		logic [1:0] edge_sel;
		logic [3:0] div_sel;
		logic [1:0] mode;
	} cpwm_cfg_s;

	typedef enum logic [1:0] {
		CPWM_IDLE,
		CPWM_UP,
		CPWM_DOWN
	} cpwm_state_e;
endpackage

// [src/cpwm_top.sv]
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cpwm_defs.svh"
module cpwm_top #(
	parameter int FIRST_PAIR = 1,
	parameter int W          = 16
) (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic             pready_out,
	output logic [31:0]      prdata_out,
	output logic             pslverr_out,
	// external count clocks
	input  wire logic        ext_clock_pin_a_in,
	input  wire logic        ext_clock_pin_b_in,
	// pwm pins
	output logic             carrier_toggle_pin_out,
	output logic             phase1_normal_pin_out,
	output logic             phase1_inverted_pin_out,
	output logic             phase2_normal_pin_out,
	output logic             phase2_inverted_pin_out,
	output logic             phase3_normal_pin_out,
	output logic             phase3_inverted_pin_out
);
	// ----------------------------------------
	// register state
	// ----------------------------------------
	cpwm_pkg::cpwm_cfg_s         cfg_q;
	cpwm_pkg::cpwm_cfg_s         cfg_wr;
	cpwm_pkg::cpwm_state_e       state_q;
	logic                        run_q;
	logic [W-1:0]                cycle_q;
	logic [W-1:0]                dead_q;
	logic [`CPWM_OCR_W-1:0]      ocr1_q;
	logic [`CPWM_OCR_W-1:0]      ocr2_q;
	logic [`CPWM_OCR_W-1:0]      lvlbuf_q;
	logic                        wprot_q;
	logic [`CPWM_CMP_W-1:0]      cmpbuf_q [3];
	logic [W-1:0]                cmp_up_q [3];
	logic [W-1:0]                cmp_dn_q [3];
	logic [W-1:0]                cnt_q;
	logic [`CPWM_PRESC_W-1:0]    presc_q;
	logic                        src_prev_q;
	logic                        tog_q;
	logic [31:0]                 prdata_q;
	logic [2:0]                  pin_n;
	logic [2:0]                  pin_i;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [3:0] div_bit(input logic [3:0] sel);
		logic [35:0] tbl;
		tbl = `CPWM_DIV_IDX;
		div_bit = (sel > 4'h8) ? tbl[35:32] : tbl[sel*4 +: 4];
	endfunction

	// compare buffer carries one half-count bit below the count
	function automatic logic [W-1:0] cmp_half(input logic [`CPWM_CMP_W-1:0] v,
			input logic dbuf, input logic second);
		cmp_half = v[`CPWM_CMP_W-1:1] + W'(dbuf & second & v[0]);
	endfunction

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire access   = psel_in & penable_in;
	wire wr       = access & pwrite_in;
	wire wr_open  = wr & wprot_q;
	wire s_run    = paddr_in == `CPWM_OFF_RUN;
	wire s_cfg    = paddr_in == `CPWM_OFF_CFG;
	wire s_cycle  = paddr_in == `CPWM_OFF_CYCLE;
	wire s_dead   = paddr_in == `CPWM_OFF_DEAD;
	wire s_ocr1   = paddr_in == `CPWM_OFF_OCR1;
	wire s_ocr2   = paddr_in == `CPWM_OFF_OCR2;
	wire s_lvlbuf = paddr_in == `CPWM_OFF_LVLBUF;
	wire s_wprot  = paddr_in == `CPWM_OFF_WPROT;
	wire s_status = paddr_in == `CPWM_OFF_STATUS;
	wire s_count  = paddr_in == `CPWM_OFF_COUNT;
	wire [2:0] s_cmp = {paddr_in == `CPWM_OFF_CMP2, paddr_in == `CPWM_OFF_CMP1,
			paddr_in == `CPWM_OFF_CMP0};
	wire mapped   = s_run | s_cfg | s_cycle | s_dead | s_ocr1 | s_ocr2 | s_lvlbuf
			| s_wprot | s_status | s_count | (|s_cmp);

	wire running  = state_q != cpwm_pkg::CPWM_IDLE;
	wire down     = state_q == cpwm_pkg::CPWM_DOWN;
	wire [1:0] status = {down, running};

	wire [31:0] rd_data =
		s_run    ? 32'(run_q) :
		s_cfg    ? 32'(cfg_q) :
		s_cycle  ? 32'(cycle_q) :
		s_dead   ? 32'(dead_q) :
		s_ocr1   ? 32'(ocr1_q) :
		s_ocr2   ? 32'(ocr2_q) :
		s_lvlbuf ? 32'(lvlbuf_q) :
		s_wprot  ? 32'(wprot_q) :
		s_cmp[0] ? 32'(cmpbuf_q[0]) :
		s_cmp[1] ? 32'(cmpbuf_q[1]) :
		s_cmp[2] ? 32'(cmpbuf_q[2]) :
		s_status ? 32'(status) :
		s_count  ? 32'(cnt_q) : 32'h0000_0000;

	// zero wait states: read data is captured in the setup cycle
	assign pready_out  = 1'h1;
	assign pslverr_out = access & ~mapped;
	assign prdata_out  = prdata_q;

	// config write: illegal combinations are dropped at the door
	always_comb begin
		cfg_wr = cpwm_pkg::cpwm_cfg_s'(pwdata_in[`CPWM_CFG_W-1:0]);
		cfg_wr.dbuf = cfg_wr.dbuf & (cfg_wr.mode == `CPWM_MODE_BOTH);
		if (FIRST_PAIR == 0) begin
			cfg_wr.clk_src = `CPWM_SRC_INT;
		end
	end

	// ----------------------------------------
	// count clock
	// ----------------------------------------
	wire div_one   = (cfg_q.clk_src == `CPWM_SRC_INT) && (cfg_q.div_sel == `CPWM_DIV_ONE);
	wire src_level = (cfg_q.clk_src == `CPWM_SRC_PIN_A) ? ext_clock_pin_a_in :
			(cfg_q.clk_src == `CPWM_SRC_PIN_B) ? ext_clock_pin_b_in :
			presc_q[div_bit(cfg_q.div_sel)];
	wire src_rise  = src_level & ~src_prev_q;
	wire src_fall  = ~src_level & src_prev_q;
	wire edge_hit  = cfg_q.edge_sel[`CPWM_EDGE_BOTH] ? (src_rise | src_fall) :
			(cfg_q.edge_sel == `CPWM_EDGE_FALL) ? src_fall : src_rise;
	wire tick      = running & (div_one | edge_hit);

	wire crest_ev  = tick & (state_q == cpwm_pkg::CPWM_UP) & (cnt_q >= cycle_q);
	wire trough_ev = tick & down & (cnt_q == '0);
	wire cmp_xfer  = (crest_ev & cfg_q.mode[`CPWM_CREST]) |
			(trough_ev & cfg_q.mode[`CPWM_TROUGH]);
	wire lvl_xfer  = cfg_q.lvl_buffered & ((crest_ev & cfg_q.lvl_trig[`CPWM_CREST]) |
			(trough_ev & cfg_q.lvl_trig[`CPWM_TROUGH]));
	wire [`CPWM_OCR_W-1:0] pol = cfg_q.lvl_buffered ? ocr2_q : ocr1_q;

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			presc_q    <= '0;
			src_prev_q <= 1'h0;
		end else begin
			presc_q    <= running ? presc_q + 1'h1 : '0;
			src_prev_q <= src_level;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			run_q    <= 1'h0;
			cfg_q    <= cpwm_pkg::cpwm_cfg_s'(`CPWM_CFG_RST);
			cycle_q  <= `CPWM_CYC_RST;
			dead_q   <= '0;
			ocr1_q   <= '0;
			ocr2_q   <= '0;
			lvlbuf_q <= '0;
			wprot_q  <= `CPWM_WP_RST;
			prdata_q <= 32'h0000_0000;
		end else begin
			if (psel_in && !penable_in && !pwrite_in) begin
				prdata_q <= rd_data;
			end
			if (wr && s_run) begin
				run_q <= pwdata_in[0];
			end
			if (wr && s_wprot) begin
				wprot_q <= pwdata_in[0];
			end
			if (wr && s_lvlbuf) begin
				lvlbuf_q <= pwdata_in[`CPWM_OCR_W-1:0];
			end
			if (wr_open && s_cfg) begin
				cfg_q <= cfg_wr;
			end
			if (wr_open && s_cycle) begin
				cycle_q <= (pwdata_in[W-1:0] < `CPWM_CYC_MIN) ? `CPWM_CYC_MIN
						: pwdata_in[W-1:0];
			end
			if (wr_open && s_dead) begin
				dead_q <= pwdata_in[W-1:0];
			end
			if (wr_open && s_ocr1) begin
				ocr1_q <= pwdata_in[`CPWM_OCR_W-1:0];
			end
			if (lvl_xfer) begin
				ocr2_q <= lvlbuf_q;
			end else if (wr_open && s_ocr2) begin
				ocr2_q <= pwdata_in[`CPWM_OCR_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// carrier counter
	// ----------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			state_q <= cpwm_pkg::CPWM_IDLE;
			cnt_q   <= '0;
			tog_q   <= 1'h0;
		end else begin
			unique case (state_q)
				cpwm_pkg::CPWM_IDLE: begin
					cnt_q <= '0;
					if (run_q) begin
						state_q <= cpwm_pkg::CPWM_UP;
					end
				end
				cpwm_pkg::CPWM_UP, cpwm_pkg::CPWM_DOWN: begin
					if (!run_q) begin
						state_q <= cpwm_pkg::CPWM_IDLE;
					end else if (crest_ev) begin
						state_q <= cpwm_pkg::CPWM_DOWN;
						cnt_q   <= cnt_q - 1'h1;
					end else if (trough_ev) begin
						state_q <= cpwm_pkg::CPWM_UP;
						cnt_q   <= cnt_q + 1'h1;
					end else if (tick) begin
						cnt_q <= down ? cnt_q - 1'h1 : cnt_q + 1'h1;
					end
				end
				default: state_q <= cpwm_pkg::CPWM_IDLE;
			endcase
			if (crest_ev) begin
				tog_q <= ~tog_q;
			end
		end
	end

	assign carrier_toggle_pin_out = cfg_q.toggle_en & tog_q;

	// ----------------------------------------
	// compare buffers and phases
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_phase
			cpwm_phase_if #(.W(W)) ph_if ();

			// software loads counts derived from its 0.1 percent duty figure
			always_ff @(posedge clock_in) begin
				if (!reset_n_in) begin
					cmpbuf_q[g] <= '0;
					cmp_up_q[g] <= '0;
					cmp_dn_q[g] <= '0;
				end else begin
					if (wr && s_cmp[g]) begin
						cmpbuf_q[g] <= pwdata_in[`CPWM_CMP_W-1:0];
					end
					if (cmp_xfer) begin
						cmp_up_q[g] <= cmp_half(cmpbuf_q[g], cfg_q.dbuf, 1'h0);
						cmp_dn_q[g] <= cmp_half(cmpbuf_q[g], cfg_q.dbuf, 1'h1);
					end
				end
			end

			assign ph_if.tick    = tick;
			assign ph_if.running = running;
			assign ph_if.down    = down;
			assign ph_if.cnt     = cnt_q;
			assign ph_if.cmp_up  = cmp_up_q[g];
			assign ph_if.cmp_dn  = cmp_dn_q[g];
			assign ph_if.dead    = dead_q;
			assign ph_if.pol_n   = pol[g];
			assign ph_if.pol_i   = pol[g+3];
			assign ph_if.pair_en = cfg_q.pair_en[g];

			cpwm_phase #(.W(W)) u_phase (
				.clock_in     (clock_in),
				.reset_n_in   (reset_n_in),
				.ph           (ph_if.phase),
				.normal_out   (pin_n[g]),
				.inverted_out (pin_i[g])
			);
		end
	endgenerate

	assign phase1_normal_pin_out   = pin_n[0];
	assign phase1_inverted_pin_out = pin_i[0];
	assign phase2_normal_pin_out   = pin_n[1];
	assign phase2_inverted_pin_out = pin_i[1];
	assign phase3_normal_pin_out   = pin_n[2];
	assign phase3_inverted_pin_out = pin_i[2];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_div_two;
		@(posedge clock_in) disable iff (!reset_n_in)
		tick && $stable(cfg_q) && cfg_q.clk_src == `CPWM_SRC_INT && cfg_q.div_sel == `CPWM_DIV_TWO
			&& cfg_q.edge_sel == `CPWM_EDGE_RISE |=> !tick;
	endproperty
	a_div_two: assert property (p_div_two) else $error("div-2 ticks too fast");

	property p_div_one;
		@(posedge clock_in) disable iff (!reset_n_in)
		run_q && div_one && state_q == cpwm_pkg::CPWM_UP && cnt_q < cycle_q
			|=> cnt_q == $past(cnt_q) + 1'h1;
	endproperty
	a_div_one: assert property (p_div_one) else $error("div-1 missed a count");

	property p_ext_pin;
		@(posedge clock_in) disable iff (!reset_n_in)
		run_q && state_q == cpwm_pkg::CPWM_UP && cnt_q < cycle_q
			&& cfg_q.clk_src == `CPWM_SRC_PIN_A && cfg_q.edge_sel == `CPWM_EDGE_RISE
			&& ext_clock_pin_a_in && !src_prev_q |=> cnt_q == $past(cnt_q) + 1'h1;
	endproperty
	a_ext_pin: assert property (p_ext_pin) else $error("pin edge not counted");

	property p_crest;
		@(posedge clock_in) disable iff (!reset_n_in)
		run_q && crest_ev |=> down && cnt_q == $past(cnt_q) - 1'h1;
	endproperty
	a_crest: assert property (p_crest) else $error("no turn at crest");

	property p_toggle;
		@(posedge clock_in) disable iff (!reset_n_in)
		crest_ev && cfg_q.toggle_en && $stable(cfg_q) |=> carrier_toggle_pin_out != $past(tog_q);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle pin missed crest");

	property p_xfer;
		@(posedge clock_in) disable iff (!reset_n_in)
		cmp_xfer |=> cmp_up_q[0] == $past(cmpbuf_q[0][`CPWM_CMP_W-1:1]);
	endproperty
	a_xfer: assert property (p_xfer) else $error("compare not transferred");

	// down half gains the half-count bit, so duty moves in single counts
	property p_dbuf_half;
		@(posedge clock_in) disable iff (!reset_n_in)
		cmp_xfer && cfg_q.dbuf |=> cmp_dn_q[0] == $past(cmpbuf_q[0][`CPWM_CMP_W-1:1])
			+ W'($past(cmpbuf_q[0][0]));
	endproperty
	a_dbuf_half: assert property (p_dbuf_half) else $error("half count lost");

	property p_lvl_xfer;
		@(posedge clock_in) disable iff (!reset_n_in)
		lvl_xfer |=> ocr2_q == $past(lvlbuf_q);
	endproperty
	a_lvl_xfer: assert property (p_lvl_xfer) else $error("level buffer not moved");

	property p_dbuf_mode;
		@(posedge clock_in) disable iff (!reset_n_in)
		cfg_q.dbuf |-> cfg_q.mode == `CPWM_MODE_BOTH;
	endproperty
	a_dbuf_mode: assert property (p_dbuf_mode) else $error("double buffer outside mode 3");

	property p_protect;
		@(posedge clock_in) disable iff (!reset_n_in)
		wr && !wprot_q && (s_cycle || s_dead) |=> $stable(cycle_q) && $stable(dead_q);
	endproperty
	a_protect: assert property (p_protect) else $error("protected write landed");

	property p_status;
		@(posedge clock_in) disable iff (!reset_n_in)
		psel_in && !penable_in && !pwrite_in && s_status |=> prdata_out[`CPWM_ST_RUN] == $past(running)
			&& prdata_out[`CPWM_ST_DOWN] == $past(down);
	endproperty
	a_status: assert property (p_status) else $error("status read wrong");
endmodule // cpwm_top
`default_nettype wire
